// ---- hw/sor_defines.svh ----
// Purpose: Offsets, field positions and reset values of the option registers
// Assumes: Byte-wide registers, each in one aligned 32-bit word
// Notes:   Definitions only
`ifndef SOR_DEFINES_SVH
`define SOR_DEFINES_SVH

`define SOR_OFFS_PIN_STOP     4'h4
`define SOR_OFFS_ROUTING      4'h5
`define SOR_OFFS_TRIG_CHAN    4'h8
`define SOR_ADDR_LSB          2
`define SOR_ADDR_W            4

`define SOR_BIT_SERIAL_PLACE  7
`define SOR_BIT_T1_PLACE      6
`define SOR_BIT_T0_PLACE      5
`define SOR_BIT_FAST_WAKE     1
`define SOR_BIT_STOP_EN       0

`define SOR_BIT_TX_MOD        7
`define SOR_BIT_RX_FILT       5
`define SOR_BIT_RX_CAPT       4
`define SOR_BIT_CMP_CAPT      3
`define SOR_BIT_OVF_CAPT      2

`define SOR_PS_FIXED_ONES     8'b0000_1100
`define SOR_PS_WO_MASK        8'b1110_0011
`define SOR_RT_RW_MASK        8'b1011_1111
`define SOR_TC_RW_MASK        8'b0000_0011
`define SOR_PS_RESET          8'h0C
`define SOR_RT_RESET          8'h00
`define SOR_TC_RESET          8'h00

`define SOR_RESP_OKAY         2'b00
`define SOR_RESP_SLVERR       2'b10

`endif

// ---- hw/sor_pkg.sv ----
// Purpose: Types for the option routing block
// Assumes: Nothing beyond the defines header
// Notes:   Trigger and channel enum codes follow the register field encodings; bus state codes are internal
`default_nettype none
package sor_pkg;
	typedef enum logic [1:0] {
		SOR_TRIG_OVERFLOW   = 2'b00,
		SOR_TRIG_COMPARATOR = 2'b01,
		SOR_TRIG_TIMER      = 2'b10,
		SOR_TRIG_TIMER_INV  = 2'b11
	} sor_trig_t;

	typedef enum logic [1:0] {
		SOR_CH_T0C0 = 2'b00,
		SOR_CH_T0C1 = 2'b01,
		SOR_CH_T1C0 = 2'b10,
		SOR_CH_T1C1 = 2'b11
	} sor_chan_t;

	typedef enum logic [1:0] {
		SOR_BUS_IDLE  = 2'b00,
		SOR_BUS_RESP  = 2'b01,
		SOR_BUS_RDATA = 2'b10
	} sor_bus_t;
endpackage
`default_nettype wire

// ---- hw/sor_sync.sv ----
// Purpose: Two-stage synchroniser with rising-edge detect
// Assumes: Input comes from outside the clk domain
// Notes:   Only the second stage and its delayed copy feed logic
`default_nettype none
module sor_sync (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic async_in,
	output logic      sync_out,
	output logic      rise_out
);
	logic meta_reg;
	logic meta_next;
	logic sync_reg;
	logic sync_next;
	logic prev_reg;
	logic prev_next;

	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
		prev_next = sync_reg;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	assign sync_out = sync_reg;
	assign rise_out = sync_reg & ~prev_reg;
endmodule
`default_nettype wire

// ---- hw/sor_top.sv ----
// Purpose: System option registers: pin placement, stop control, signal routing
// Assumes: AXI4-Lite slave on clk; routed signals arrive asynchronously
// Notes:   Outputs are registered, so routed paths carry three cycles of latency
//
// Overview of operation
// (RQ1) Bit 7 write-once: serial pins placement
// (RQ2) Bit 6 write-once: timer one pins placement
// (RQ3) Bit 5 write-once: timer zero pins placement
// (RQ4) Bit 4 reads 0, bits 3-2 read 1
// (RQ5) Bit 1 write-once: fast wakeup, skip service
// (RQ6) Software avoids interrupts 0-8 cycles after stop
// (RQ7) Bit 0 write-once stop enable, resets 0
// (RQ8) Stop while disabled gives illegal-opcode reset
// (RQ9) Write-once bits take first write only
// (RQ10) Routing register freely writable at any time
// (RQ11) Software writes routing register at initialisation
// (RQ12) Bit 7: transmit modulated by timer0 channel0
// (RQ13) Bit 6 reserved, reads 0, ignores writes
// (RQ14) Bit 5: receive filtered through comparator
// (RQ15) Bit 4: receive also to timer0 channel1
// (RQ16) Bit 3: comparator to timer1 channel0
// (RQ17) Bit 2: counter overflow to timer1 channel1
// (RQ18) Bits 1-0 select converter trigger source
// (RQ19) Selected source triggers on rising edge
// (RQ20) Channel select picks timer trigger source
`include "sor_defines.svh"
`default_nettype none
module sor_top (
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic [31:0]         s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [31:0]         s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                stop_request,
	input  wire logic                serial_transmit_line,
	input  wire logic                serial_receive_line,
	input  wire logic                analog_comparator,
	input  wire logic                counter_overflow,
	input  wire logic [3:0]          timer_channels,
	output logic                     serial_pin_place,
	output logic                     timer1_pin_place,
	output logic                     timer0_pin_place,
	output logic                     fast_wakeup_enable,
	output logic                     stop_mode_enable,
	output logic                     stop_enter,
	output logic                     illegal_opcode_reset,
	output logic                     serial_tx_pin,
	output logic                     serial_rx_to_port,
	output logic                     timer_zero_ch1_in,
	output logic                     timer_one_ch0_in,
	output logic                     timer_one_ch1_in,
	output logic                     converter_trigger
);
	import sor_pkg::*;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] raw_in, syn, syn_rise;

	assign raw_in = {timer_channels, counter_overflow, analog_comparator,
			serial_receive_line, serial_transmit_line, stop_request};

	for (genvar gi = 0; gi < NSYNC; gi++) begin : g_sync
		sor_sync u_sync (
			.clk      (clk),
			.resetn   (resetn),
			.async_in (raw_in[gi]),
			.sync_out (syn[gi]),
			.rise_out (syn_rise[gi])
		);
	end

	logic       stop_rise, tx_s, rx_s, cmp_s, ovf_s;
	logic [3:0] tch_s;
	assign stop_rise = syn_rise[0];
	assign tx_s      = syn[1];
	assign rx_s      = syn[2];
	assign cmp_s     = syn[3];
	assign ovf_s     = syn[4];
	assign tch_s     = syn[8:5];

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	sor_bus_t    wst_reg, wst_next;
	sor_bus_t    rst_reg, rst_next;
	logic        aw_have_reg, aw_have_next;
	logic        w_have_reg, w_have_next;
	logic [31:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic        wlane_reg, wlane_next;
	logic [1:0]  bresp_reg, bresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0]  rresp_reg, rresp_next;
	logic [7:0]  ps_reg, ps_next;
	logic [7:0]  rt_reg, rt_next;
	logic [7:0]  tc_reg, tc_next;
	logic        written_reg, written_next;
	logic        do_write, waddr_ok, raddr_ok;
	logic [`SOR_ADDR_W-1:0] wofs, rofs;
	assign wofs     = awaddr_reg[`SOR_ADDR_LSB +: `SOR_ADDR_W];
	assign rofs     = s_axi_araddr[`SOR_ADDR_LSB +: `SOR_ADDR_W];
	assign waddr_ok = (awaddr_reg[31:`SOR_ADDR_LSB+`SOR_ADDR_W] == '0);
	assign raddr_ok = (s_axi_araddr[31:`SOR_ADDR_LSB+`SOR_ADDR_W] == '0);
	assign do_write = (wst_reg == SOR_BUS_IDLE) && aw_have_reg && w_have_reg;

	function automatic logic [7:0] reg_read(input logic [`SOR_ADDR_W-1:0] ofs,
			input logic [7:0] ps, input logic [7:0] rt, input logic [7:0] tc);
		case (ofs)
			`SOR_OFFS_PIN_STOP:  reg_read = ps;
			`SOR_OFFS_ROUTING:   reg_read = rt;
			`SOR_OFFS_TRIG_CHAN: reg_read = tc;
			default:             reg_read = 8'h00;
		endcase
	endfunction

	// Each register owns the word at four times its index; its byte is lane 0
	always_comb begin
		wst_next     = wst_reg;
		aw_have_next = aw_have_reg;
		w_have_next  = w_have_reg;
		awaddr_next  = awaddr_reg;
		wdata_next   = wdata_reg;
		wlane_next   = wlane_reg;
		bresp_next   = bresp_reg;
		ps_next      = ps_reg;
		rt_next      = rt_reg;
		tc_next      = tc_reg;
		written_next = written_reg;
		if (s_axi_awvalid && !aw_have_reg) begin
			aw_have_next = 1'b1;
			awaddr_next  = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_have_reg) begin
			w_have_next = 1'b1;
			wdata_next  = s_axi_wdata;
			wlane_next  = s_axi_wstrb[0];
		end
		case (wst_reg)
			SOR_BUS_IDLE: begin
				if (do_write) begin
					aw_have_next = 1'b0;
					w_have_next  = 1'b0;
					wst_next     = SOR_BUS_RESP;
					bresp_next   = `SOR_RESP_OKAY;
					if (!waddr_ok) begin
						bresp_next = `SOR_RESP_SLVERR;
					end else if (wofs == `SOR_OFFS_PIN_STOP) begin
						// First write after reset locks the whole register
						if (wlane_reg && !written_reg) begin // RQ9
							ps_next = (wdata_reg[7:0] & `SOR_PS_WO_MASK) // RQ1 RQ2 RQ3 RQ5 RQ7
								| `SOR_PS_FIXED_ONES; // RQ4
							written_next = 1'b1; // RQ9
						end
					end else if (wofs == `SOR_OFFS_ROUTING) begin
						if (wlane_reg) begin
							rt_next = wdata_reg[7:0] & `SOR_RT_RW_MASK; // RQ10 RQ13
						end
					end else if (wofs == `SOR_OFFS_TRIG_CHAN) begin
						if (wlane_reg) begin
							tc_next = wdata_reg[7:0] & `SOR_TC_RW_MASK; // RQ20
						end
					end else begin
						bresp_next = `SOR_RESP_SLVERR;
					end
				end
			end
			SOR_BUS_RESP: begin
				if (s_axi_bready) begin
					wst_next = SOR_BUS_IDLE;
				end
			end
			default: wst_next = SOR_BUS_IDLE;
		endcase
	end

	always_comb begin
		rst_next   = rst_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		case (rst_reg)
			SOR_BUS_IDLE: begin
				if (s_axi_arvalid) begin
					rst_next   = SOR_BUS_RDATA;
					rdata_next = {24'h0000_00, reg_read(rofs, ps_reg, rt_reg, tc_reg)};
					rresp_next = `SOR_RESP_OKAY;
					if (!raddr_ok || (rofs != `SOR_OFFS_PIN_STOP && rofs != `SOR_OFFS_ROUTING
							&& rofs != `SOR_OFFS_TRIG_CHAN)) begin
						rresp_next = `SOR_RESP_SLVERR;
					end
				end
			end
			SOR_BUS_RDATA: begin
				if (s_axi_rready) begin
					rst_next = SOR_BUS_IDLE;
				end
			end
			default: rst_next = SOR_BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wst_reg     <= SOR_BUS_IDLE;
			rst_reg     <= SOR_BUS_IDLE;
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			awaddr_reg  <= 32'h0000_0000;
			wdata_reg   <= 32'h0000_0000;
			wlane_reg   <= 1'b0;
			bresp_reg   <= `SOR_RESP_OKAY;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= `SOR_RESP_OKAY;
			ps_reg      <= `SOR_PS_RESET; // RQ7
			rt_reg      <= `SOR_RT_RESET;
			tc_reg      <= `SOR_TC_RESET;
			written_reg <= 1'b0;
		end else begin
			wst_reg     <= wst_next;
			rst_reg     <= rst_next;
			aw_have_reg <= aw_have_next;
			w_have_reg  <= w_have_next;
			awaddr_reg  <= awaddr_next;
			wdata_reg   <= wdata_next;
			wlane_reg   <= wlane_next;
			bresp_reg   <= bresp_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
			ps_reg      <= ps_next;
			rt_reg      <= rt_next;
			tc_reg      <= tc_next;
			written_reg <= written_next;
		end
	end

	assign s_axi_awready = !aw_have_reg;
	assign s_axi_wready  = !w_have_reg;
	assign s_axi_bvalid  = (wst_reg == SOR_BUS_RESP);
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = (rst_reg == SOR_BUS_IDLE);
	assign s_axi_rvalid  = (rst_reg == SOR_BUS_RDATA);
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// ------------------------------------------------------------
	// Signal routing and stop control
	// ------------------------------------------------------------
	sor_trig_t   trig_sel;
	sor_chan_t   chan_sel;
	logic        rx_path, timer_pick, trig_level;
	logic        trig_prev_reg, trig_prev_next;
	logic [10:0] out_reg, out_next;

	assign trig_sel = sor_trig_t'(rt_reg[1:0]);
	assign chan_sel = sor_chan_t'(tc_reg[1:0]);

	always_comb begin
		// Comparator output stands in for the receive line when filtering
		rx_path = rt_reg[`SOR_BIT_RX_FILT] ? cmp_s : rx_s; // RQ14
		case (chan_sel)
			SOR_CH_T0C0: timer_pick = tch_s[0]; // RQ20
			SOR_CH_T0C1: timer_pick = tch_s[1];
			SOR_CH_T1C0: timer_pick = tch_s[2];
			SOR_CH_T1C1: timer_pick = tch_s[3];
			default:     timer_pick = 1'b0;
		endcase
		case (trig_sel)
			SOR_TRIG_OVERFLOW:   trig_level = ovf_s; // RQ18
			SOR_TRIG_COMPARATOR: trig_level = cmp_s;
			SOR_TRIG_TIMER:      trig_level = timer_pick;
			SOR_TRIG_TIMER_INV:  trig_level = ~timer_pick; // RQ19
			default:             trig_level = 1'b0;
		endcase
		trig_prev_next = trig_level;
		out_next[0]  = ps_reg[`SOR_BIT_SERIAL_PLACE]; // RQ1
		out_next[1]  = ps_reg[`SOR_BIT_T1_PLACE]; // RQ2
		out_next[2]  = ps_reg[`SOR_BIT_T0_PLACE]; // RQ3
		out_next[3]  = ps_reg[`SOR_BIT_FAST_WAKE]; // RQ5
		out_next[4]  = ps_reg[`SOR_BIT_STOP_EN]; // RQ7
		// Stop is only pulsed here, one cycle per request edge; the core owns the stop entry itself
		out_next[5]  = stop_rise && ps_reg[`SOR_BIT_STOP_EN];
		out_next[6]  = stop_rise && !ps_reg[`SOR_BIT_STOP_EN]; // RQ8
		// Modulation gates the transmit line with the carrier channel
		out_next[7]  = rt_reg[`SOR_BIT_TX_MOD] ? (tx_s & tch_s[0]) : tx_s; // RQ12
		out_next[8]  = rx_path;
		// Capture paths read zero when disconnected
		out_next[9]  = rt_reg[`SOR_BIT_RX_CAPT] & rx_path; // RQ15
		out_next[10] = trig_level & ~trig_prev_reg; // RQ19
	end

	logic t1c0_reg, t1c0_next;
	logic t1c1_reg, t1c1_next;
	assign t1c0_next = rt_reg[`SOR_BIT_CMP_CAPT] & cmp_s; // RQ16
	assign t1c1_next = rt_reg[`SOR_BIT_OVF_CAPT] & ovf_s; // RQ17

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			out_reg       <= 11'h000;
			trig_prev_reg <= 1'b1;
			t1c0_reg      <= 1'b0;
			t1c1_reg      <= 1'b0;
		end else begin
			out_reg       <= out_next;
			trig_prev_reg <= trig_prev_next;
			t1c0_reg      <= t1c0_next;
			t1c1_reg      <= t1c1_next;
		end
	end

	assign serial_pin_place     = out_reg[0];
	assign timer1_pin_place     = out_reg[1];
	assign timer0_pin_place     = out_reg[2];
	assign fast_wakeup_enable   = out_reg[3];
	assign stop_mode_enable     = out_reg[4];
	assign stop_enter           = out_reg[5];
	assign illegal_opcode_reset = out_reg[6];
	assign serial_tx_pin        = out_reg[7];
	assign serial_rx_to_port    = out_reg[8];
	assign timer_zero_ch1_in    = out_reg[9];
	assign converter_trigger    = out_reg[10];
	assign timer_one_ch0_in     = t1c0_reg;
	assign timer_one_ch1_in     = t1c1_reg;
endmodule
`default_nettype wire

// ---- verif/sor_top_properties.sv ----
// Purpose: Port-level assertions for the option routing block
// Assumes: One clock domain, resetn asynchronous and active low
// Notes:   Routed inputs pass a synchroniser, so checks allow a few cycles
`default_nettype none
module sor_top_properties (
	input wire logic		clk,
	input wire logic		resetn,
	input wire logic		s_axi_arvalid,
	input wire logic		s_axi_arready,
	input wire logic [31:0]	s_axi_araddr,
	input wire logic		s_axi_rvalid,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic [1:0]	s_axi_rresp,
	input wire logic		stop_request,
	input wire logic		stop_mode_enable,
	input wire logic		stop_enter,
	input wire logic		illegal_opcode_reset,
	input wire logic		serial_pin_place,
	input wire logic		timer1_pin_place,
	input wire logic		timer0_pin_place,
	input wire logic		fast_wakeup_enable,
	input wire logic		serial_transmit_line,
	input wire logic		serial_tx_pin,
	input wire logic		analog_comparator,
	input wire logic		timer_one_ch0_in,
	input wire logic		counter_overflow,
	input wire logic		timer_one_ch1_in,
	input wire logic		converter_trigger
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]	rd_idx_reg;
	logic [3:0]	rd_idx_next;

	// ---------------------------------------------
	// Word index of the read under way
	// ---------------------------------------------
	always_comb begin
		rd_idx_next = rd_idx_reg;
		if (s_axi_arvalid && s_axi_arready)
			rd_idx_next = s_axi_araddr[5:2];
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rd_idx_reg <= 4'h0;
		else
			rd_idx_reg <= rd_idx_next;
	end

	// ---------------------------------------------
	// Properties
	// ---------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_ps_fixed;
		s_axi_rvalid && rd_idx_reg == 4'h4 && s_axi_rresp == 2'b00 |-> s_axi_rdata[4:2] == 3'b011;
	endproperty
	a_ps_fixed: assert property (p_ps_fixed) else $error("pin options fixed bits wrong");

	property p_rt_rsvd;
		s_axi_rvalid && rd_idx_reg == 4'h5 && s_axi_rresp == 2'b00 |-> !s_axi_rdata[6];
	endproperty
	a_rt_rsvd: assert property (p_rt_rsvd) else $error("routing reserved bit set");

	property p_stop_ok;
		$rose(stop_request) && stop_mode_enable |-> ##[1:6] stop_enter;
	endproperty
	a_stop_ok: assert property (p_stop_ok) else $error("enabled stop not entered");

	property p_stop_bad;
		$rose(stop_request) && !stop_mode_enable |-> ##[1:6] illegal_opcode_reset;
	endproperty
	a_stop_bad: assert property (p_stop_bad) else $error("illegal stop not reset");

	// Locked bits can only be set once, so none may ever fall outside reset
	property p_lock;
		!($fell(serial_pin_place) || $fell(timer1_pin_place) || $fell(timer0_pin_place)
			|| $fell(fast_wakeup_enable) || $fell(stop_mode_enable));
	endproperty
	a_lock: assert property (p_lock) else $error("write-once bit changed");

	property p_tx;
		(!serial_transmit_line) [*4] |=> !serial_tx_pin;
	endproperty
	a_tx: assert property (p_tx) else $error("tx pin high with tx low");

	property p_cmp;
		(!analog_comparator) [*4] |=> !timer_one_ch0_in;
	endproperty
	a_cmp: assert property (p_cmp) else $error("comparator capture without comparator");

	property p_ovf;
		(!counter_overflow) [*4] |=> !timer_one_ch1_in;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow capture without overflow");

	property p_trig;
		converter_trigger |=> !converter_trigger;
	endproperty
	a_trig: assert property (p_trig) else $error("trigger pulse too long");

	c_stop: cover property (stop_enter);
	c_ill: cover property (illegal_opcode_reset);
	c_trig: cover property (converter_trigger);
endmodule

bind sor_top sor_top_properties u_props (
	.clk, .resetn, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
	.s_axi_rdata, .s_axi_rresp, .stop_request, .stop_mode_enable, .stop_enter,
	.illegal_opcode_reset, .serial_pin_place, .timer1_pin_place, .timer0_pin_place,
	.fast_wakeup_enable, .serial_transmit_line, .serial_tx_pin, .analog_comparator,
	.timer_one_ch0_in, .counter_overflow, .timer_one_ch1_in, .converter_trigger
);
`default_nettype wire

// ---- verif/tb_system_option_routing_regs.sv ----
// Purpose: Register and routing bench for the option routing block
// Assumes: AXI4-Lite master tasks, 50 MHz clock
// Notes:   Routed outputs are compared once the synchroniser has settled
`default_nettype none
module tb_system_option_routing_regs;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] A_PS = 32'h0000_0010;
	localparam logic [31:0] A_RT = 32'h0000_0014;
	localparam logic [31:0] A_TC = 32'h0000_0020;
	localparam logic [31:0] A_BAD = 32'h0000_0000;
	logic			clk, resetn, stop_request, counter_overflow, analog_comparator;
	logic [31:0]	s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]		s_axi_wstrb, timer_channels;
	logic [1:0]		s_axi_bresp, s_axi_rresp;
	logic			s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic			s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic			serial_transmit_line, serial_receive_line, serial_pin_place, timer1_pin_place;
	logic			timer0_pin_place, fast_wakeup_enable, stop_mode_enable, stop_enter;
	logic			illegal_opcode_reset, serial_tx_pin, serial_rx_to_port, timer_zero_ch1_in;
	logic			timer_one_ch0_in, timer_one_ch1_in, converter_trigger;
	logic [7:0]		rt_vals [2] = '{8'hBC, 8'h00};
	int				errors = 0;
	int				n_checks = 0;

	sor_top dut (
		.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .stop_request, .serial_transmit_line, .serial_receive_line,
		.analog_comparator, .counter_overflow, .timer_channels, .serial_pin_place,
		.timer1_pin_place, .timer0_pin_place, .fast_wakeup_enable, .stop_mode_enable,
		.stop_enter, .illegal_opcode_reset, .serial_tx_pin, .serial_rx_to_port,
		.timer_zero_ch1_in, .timer_one_ch0_in, .timer_one_ch1_in, .converter_trigger
	);

	// ---------------------------------------------
	// Checking and bus tasks
	// ---------------------------------------------
	task automatic chk_v(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chk_n(input string nm, input int exp, input int got);
		n_checks++;
		if (got != exp) begin
			errors++;
			$display("FAIL %s expected %0d seen %0d", nm, exp, got);
		end
	endtask

	task automatic print_verdict();
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Address and data are released independently, whichever is taken first
	task automatic axi_wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] resp);
		bit ha, hw, hb;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_wstrb <= 4'h1;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(negedge clk);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			hb = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge clk);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
			if (hb) break;
		end
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
		bit ha, hr;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(negedge clk);
			ha = s_axi_arvalid && s_axi_arready;
			hr = s_axi_rvalid;
			d = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge clk);
			if (ha) s_axi_arvalid <= 1'b0;
			if (hr) break;
		end
		s_axi_rready <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk_v("bresp", 32'h0000_0000, {30'h0000_0000, r});
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk_v("rresp", 32'h0000_0000, {30'h0000_0000, r});
		chk_v("rdata", exp, d);
	endtask

	task automatic do_reset();
		@(posedge clk);
		resetn <= 1'b0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
	endtask

	task automatic settle();
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask

	function automatic logic [31:0] pins();
		return {27'h000_0000, serial_pin_place, timer1_pin_place, timer0_pin_place,
			fast_wakeup_enable, stop_mode_enable};
	endfunction

	task automatic count_p(output int nt, output int ns, output int ni);
		nt = 0;
		ns = 0;
		ni = 0;
		repeat (10) begin
			@(negedge clk);
			nt += (converter_trigger === 1'b1);
			ns += (stop_enter === 1'b1);
			ni += (illegal_opcode_reset === 1'b1);
		end
	endtask

	task automatic stop_try(input int e_ns, input int e_ni);
		int nt, ns, ni;
		@(posedge clk);
		stop_request <= 1'b1;
		count_p(nt, ns, ni);
		chk_n("stop enter", e_ns, ns);
		chk_n("illegal reset", e_ni, ni);
		@(posedge clk);
		stop_request <= 1'b0;
	endtask

	// Sources park at their idle level before the selection changes
	task automatic trig_try(input logic [1:0] code, input logic [1:0] ch);
		int nt, ns, ni;
		logic idle;
		idle = (code == 2'b11);
		@(posedge clk);
		counter_overflow <= 1'b0;
		analog_comparator <= 1'b0;
		timer_channels <= {4{idle}};
		repeat (6) @(posedge clk);
		wr(A_TC, {6'h00, ch});
		rd_chk(A_TC, {30'h0000_0000, ch});
		wr(A_RT, {6'h00, code});
		repeat (8) @(posedge clk);
		if (code[1]) begin
			timer_channels[ch + 2'd1] <= ~idle;
			count_p(nt, ns, ni);
			chk_n("unselected channel", 0, nt);
			@(posedge clk);
		end
		case (code)
			2'b00: counter_overflow <= 1'b1;
			2'b01: analog_comparator <= 1'b1;
			default: timer_channels[ch] <= ~idle;
		endcase
		count_p(nt, ns, ni);
		chk_n("trigger pulses", 1, nt);
	endtask

	// ---------------------------------------------
	// Clock, watchdog and sequence
	// ---------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		print_verdict();
	end

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb, timer_channels, s_axi_awvalid,
			s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, stop_request, resetn,
			serial_transmit_line, serial_receive_line, analog_comparator, counter_overflow} = '0;
		do_reset();
		rd_chk(A_PS, 32'h0000_000C);
		rd_chk(A_RT, 32'h0000_0000);
		wr(A_RT, 8'h00);
		axi_rd(A_BAD, d, r);
		chk_v("unmapped rresp", 32'h0000_0002, {30'h0000_0000, r});
		chk_v("unmapped rdata", 32'h0000_0000, d);
		axi_wr(A_BAD, 8'hFF, r);
		chk_v("unmapped bresp", 32'h0000_0002, {30'h0000_0000, r});
		wr(A_PS, 8'hA2);
		wr(A_PS, 8'h5D);
		rd_chk(A_PS, 32'h0000_00AE);
		settle();
		chk_v("pin outputs", 32'h0000_0016, pins());
		stop_try(0, 1);
		do_reset();
		chk_v("pin outputs", 32'h0000_0000, pins());
		wr(A_PS, 8'h5D);
		wr(A_PS, 8'hA2);
		rd_chk(A_PS, 32'h0000_004D);
		settle();
		chk_v("pin outputs", 32'h0000_0009, pins());
		stop_try(1, 0);
		wr(A_RT, 8'hFF);
		rd_chk(A_RT, 32'h0000_00BF);
		@(posedge clk);
		serial_transmit_line <= 1'b1;
		analog_comparator <= 1'b1;
		counter_overflow <= 1'b1;
		foreach (rt_vals[i]) begin
			wr(A_RT, rt_vals[i]);
			rd_chk(A_RT, {24'h00_0000, rt_vals[i]});
			settle();
			chk_v("routed", {27'h000_0000, ~rt_vals[i][7], rt_vals[i][5:2]}, {27'h000_0000,
				serial_tx_pin, serial_rx_to_port, timer_zero_ch1_in, timer_one_ch0_in,
				timer_one_ch1_in});
		end
		for (int c = 0; c < 4; c++) trig_try(2'(c), 2'b01);
		for (int c = 0; c < 4; c++) trig_try(2'b10, 2'(c));
		print_verdict();
	end
endmodule
`default_nettype wire
